// >>> adc_rt_consts.svh
// Offsets, field positions, reset values and timing counts of the result mover
`ifndef ADC_RT_CONSTS_SVH
`define ADC_RT_CONSTS_SVH

`define OFS_CTRL       8'h00
`define OFS_COUNT      8'h04
`define OFS_START      8'h08
`define OFS_RESULT     8'h0c
`define OFS_STATUS     8'h10

`define BIT_TWO_BLOCK  0
`define BIT_CONT       1
`define BIT_B1_FULL    2
`define BIT_IRQ_EN     3
`define BIT_IRQ_FLAG   4
`define BIT_ENC        5
`define CHAN_LO        8
`define CHAN_HI        11

`define ST_BIT_CONV    0
`define ST_BIT_ACTIVE  1
`define ST_BIT_BUSY    2

`define START_RESET    16'h0200
`define CHAN_TEMP      4'ha
`define ADDR_STEP      16'h0002
`define SYNC_ACTIVE    2'h1
`define SYNC_SLEEP     2'h2

`define CLK_PERIOD_NS  4
`define OSC_START_NS   2000
`define OSC_START_CYC  ((`OSC_START_NS) / (`CLK_PERIOD_NS))

`endif

// >>> adc_rt_pkg.sv
// Types of the result mover
`default_nettype none

package adc_rt_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_XFER, ST_WAIT} xfer_state_t;

  typedef struct packed {
    xfer_state_t st;
    logic [1:0]  sync_cnt;
    logic [9:0]  osc_cnt;
    logic [15:0] ptr;
    logic [7:0]  cnt;
    logic        in_b2;
    logic        done;
    logic        b1_full;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        halt;
    logic        mclk_req;
    logic        two_block;
    logic        cont;
    logic        irq_en;
    logic        conversion_enable_gate;
    logic [3:0]  chan;
    logic [7:0]  count;
    logic [15:0] start;
    logic [15:0] result;
    logic        ack;
    logic [31:0] rdat;
  } rt_state_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

endpackage

`default_nettype wire

// >>> sticky_flag.sv
// Sticky flag whose set wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none

module sticky_flag
  import adc_rt_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  flag_state_t s;
  flag_state_t next_s;

  always_comb begin
    next_s = s;
    if (set) begin
      next_s.flag = 1'b1;
    end else if (clr) begin
      next_s.flag = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flag = s.flag;

endmodule // sticky_flag

`default_nettype wire

// >>> adc_result_transfer_ctrl.sv
// Converter result mover: copies each new result word into memory blocks
//
// Overview of operation
// - Mover is active when transfer count is nonzero, idle when zero.
// - While active, each new result load triggers exactly one transfer.
// - A transfer owns the memory bus one cycle; CPU halted then.
// - One-block mode: n words from start address to start+2n-2.
// - Pointer starts at start, counter at n; each write adds two, counts down.
// - One-block mode stops at count zero until start address written.
// - One-block mode raises interrupt flag only after whole block.
// - Two-block mode fills start..start+2n-2 then start+2n..start+4n-2.
// - Block one done: set flag and block-one-full, reload n, go block two.
// - Block two done: set flag, clear block-one-full.
// - Continuous: after final block, pointer to start, counter to n.
// - Continuous cleared: stop after final block of current pass.
// - Transfer is sync cycles, one bus write cycle, one wait cycle.
// - Clock running, CPU off: transfer without waking CPU.
// - Clock stopped: request it only for the transfer, CPU stays off.
// - Worst case 3 cycles active, 4 asleep, plus oscillator start time.
// - Temperature channel code turns reference on, nothing else changes.
// - Transfer count zero: every result load sets the interrupt flag.
// - Interrupt request when flag, enable and global enable all set.
// - Flag clears when serviced, and by software write.
// - Continuous mode stops only by clearing continuous or writing a zero count.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

`include "adc_rt_consts.svh"

module adc_result_transfer_ctrl
  import adc_rt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  input  wire logic        RESULT_LOAD,
  input  wire logic [15:0] RESULT_DATA,
  input  wire logic        CONVERTER_ACTIVE,
  input  wire logic        GLOBAL_IRQ_ENABLE,
  input  wire logic        IRQ_SERVICED,
  input  wire logic        CPU_ON,
  input  wire logic        MCLK_RUNNING,
  output logic [15:0]      MEM_ADDR,
  output logic [15:0]      MEM_WDATA,
  output logic             MEM_WE,
  output logic             CPU_HALT,
  output logic             MCLK_REQ,
  output logic             IRQ,
  output logic             CONVERSION_ENABLE_GATE,
  output logic [3:0]       INPUT_CHANNEL_SELECT,
  output logic             REF_ON
);

  localparam logic [9:0] OSC_WAIT = 10'(`OSC_START_CYC);

  rt_state_t   s;
  rt_state_t   next_s;
  logic        req;
  logic        wr;
  logic        sa_write;
  logic        cnt_write;
  logic        ctrl_write;
  logic        mover_active;
  logic        pend;
  logic        pend_set;
  logic        pend_clr;
  logic        irq_flag;
  logic        irq_set;
  logic        irq_clr;
  logic        last_word;
  logic        block_done;
  logic [1:0]  sync_need;
  logic        clk_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req        = CYC_I && STB_I && !s.ack;
  assign wr         = req && WE_I;
  assign sa_write   = wr && (ADR_I == `OFS_START);
  assign cnt_write  = wr && (ADR_I == `OFS_COUNT) && SEL_I[0];
  assign ctrl_write = wr && (ADR_I == `OFS_CTRL);

  assign mover_active = (s.count != 8'h00) && !s.done;
  assign last_word    = (s.cnt == 8'h01);
  assign block_done   = (s.st == ST_XFER) && last_word;

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  assign pend_set = RESULT_LOAD && mover_active;
  assign pend_clr = (s.st == ST_IDLE) && pend;

  sticky_flag u_pend (
    .clk  (CLK),
    .rst  (RST),
    .set  (pend_set),
    .clr  (pend_clr),
    .flag (pend)
  );

  assign irq_set = block_done
                || (RESULT_LOAD && (s.count == 8'h00));
  assign irq_clr = IRQ_SERVICED
                || (ctrl_write && SEL_I[0] && DAT_I[`BIT_IRQ_FLAG]);

  sticky_flag u_irq (
    .clk  (CLK),
    .rst  (RST),
    .set  (irq_set),
    .clr  (irq_clr),
    .flag (irq_flag)
  );

  assign sync_need = CPU_ON ? `SYNC_ACTIVE : `SYNC_SLEEP;
  assign clk_ok    = MCLK_RUNNING || (s.osc_cnt == OSC_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s     = s;
    next_s.ack = req;
    next_s.we  = 1'b0;
    next_s.halt = 1'b0;

    // Register writes
    if (ctrl_write && SEL_I[0]) begin
      next_s.two_block = DAT_I[`BIT_TWO_BLOCK];
      next_s.cont      = DAT_I[`BIT_CONT];
      next_s.irq_en    = DAT_I[`BIT_IRQ_EN];
      next_s.conversion_enable_gate       = DAT_I[`BIT_ENC];
    end
    if (ctrl_write && SEL_I[1]) begin
      next_s.chan = DAT_I[`CHAN_HI:`CHAN_LO];
    end
    if (cnt_write) begin
      next_s.count = DAT_I[7:0];
      next_s.cnt   = DAT_I[7:0];
    end
    if (RESULT_LOAD) begin
      next_s.result = RESULT_DATA;
    end

    // Read data
    if (req && !WE_I) begin
      case (ADR_I)
        `OFS_CTRL: begin
          next_s.rdat = '0;
          next_s.rdat[`BIT_TWO_BLOCK] = s.two_block;
          next_s.rdat[`BIT_CONT]      = s.cont;
          next_s.rdat[`BIT_B1_FULL]   = s.b1_full;
          next_s.rdat[`BIT_IRQ_EN]    = s.irq_en;
          next_s.rdat[`BIT_IRQ_FLAG]  = irq_flag;
          next_s.rdat[`BIT_ENC]       = s.conversion_enable_gate;
          next_s.rdat[`CHAN_HI:`CHAN_LO] = s.chan;
        end
        `OFS_COUNT:  next_s.rdat = {24'h000000, s.count};
        `OFS_START:  next_s.rdat = {16'h0000, s.start};
        `OFS_RESULT: next_s.rdat = {16'h0000, s.result};
        `OFS_STATUS: begin
          next_s.rdat = '0;
          next_s.rdat[`ST_BIT_CONV]   = CONVERTER_ACTIVE;
          next_s.rdat[`ST_BIT_ACTIVE] = mover_active;
          next_s.rdat[`ST_BIT_BUSY]   = (s.st != ST_IDLE);
        end
        default: next_s.rdat = '0;
      endcase
    end

    // Transfer sequence
    case (s.st)
      ST_IDLE: begin
        next_s.sync_cnt = 2'h0;
        next_s.osc_cnt  = 10'h000;
        if (pend && mover_active) begin
          next_s.st       = ST_SYNC;
          next_s.mclk_req = 1'b1;
        end
      end
      ST_SYNC: begin
        if (!MCLK_RUNNING && s.osc_cnt != OSC_WAIT) begin
          next_s.osc_cnt = s.osc_cnt + 10'h001;
        end
        if (s.sync_cnt != 2'h3) begin
          next_s.sync_cnt = s.sync_cnt + 2'h1;
        end
        if (clk_ok && (3'(s.sync_cnt) + 3'h1 >= 3'(sync_need))) begin
          next_s.st    = ST_XFER;
          next_s.we    = 1'b1;
          next_s.halt  = CPU_ON;
          next_s.addr  = s.ptr;
          next_s.wdata = s.result;
        end
      end
      ST_XFER: begin
        next_s.st  = ST_WAIT;
        next_s.ptr = s.ptr + `ADDR_STEP;
        next_s.cnt = s.cnt - 8'h01;
        if (last_word) begin
          if (s.two_block && !s.in_b2) begin
            next_s.in_b2   = 1'b1;
            next_s.b1_full = 1'b1;
            next_s.cnt     = s.count;
          end else begin
            if (s.two_block) begin
              next_s.b1_full = 1'b0;
            end
            if (s.cont) begin
              next_s.ptr   = s.start;
              next_s.cnt   = s.count;
              next_s.in_b2 = 1'b0;
            end else begin
              next_s.done = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        next_s.st       = ST_IDLE;
        next_s.mclk_req = 1'b0;
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Start address write re-arms from block one
    if (sa_write) begin
      if (SEL_I[0]) begin
        next_s.start[7:0] = DAT_I[7:0];
      end
      if (SEL_I[1]) begin
        next_s.start[15:8] = DAT_I[15:8];
      end
      next_s.ptr     = next_s.start;
      next_s.cnt     = s.count;
      next_s.done    = 1'b0;
      next_s.in_b2   = 1'b0;
      next_s.b1_full = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s       <= '0;
      s.start <= `START_RESET;
      s.ptr   <= `START_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DAT_O                  = s.rdat;
  assign ACK_O                  = s.ack;
  assign MEM_ADDR               = s.addr;
  assign MEM_WDATA              = s.wdata;
  assign MEM_WE                 = s.we;
  assign CPU_HALT               = s.halt;
  assign MCLK_REQ               = s.mclk_req && !CPU_ON;
  assign IRQ                    = irq_flag && s.irq_en && GLOBAL_IRQ_ENABLE;
  assign CONVERSION_ENABLE_GATE = s.conversion_enable_gate;
  assign INPUT_CHANNEL_SELECT   = s.chan;
  assign REF_ON                 = (s.chan == `CHAN_TEMP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_idle_at_zero:
    assert property ((s.count == 8'h00) && (s.st == ST_IDLE) |=> (s.st == ST_IDLE))
    else $error("Mover left idle with zero transfer count");

  a_load_to_write:
    assert property ((s.st == ST_IDLE) && pend && mover_active && CPU_ON && MCLK_RUNNING
                     |-> ##2 s.we)
    else $error("Result load did not reach the bus in time");

  a_halt_single:
    assert property (CPU_HALT |-> MEM_WE ##1 !CPU_HALT)
    else $error("CPU halt longer than the bus write");

  a_ptr_step:
    assert property (s.we && !sa_write |=> (s.ptr == s.addr + `ADDR_STEP) || (s.ptr == s.start))
    else $error("Pointer did not advance by two");

  a_cnt_step:
    assert property ((s.st == ST_XFER) && (s.cnt > 8'h01) && !sa_write && !cnt_write
                     |=> s.cnt == $past(s.cnt) - 8'h01)
    else $error("Counter did not count down by one");

  a_stop_hold:
    assert property (s.done && !sa_write |=> s.done && !s.we)
    else $error("Transfers resumed without a start address write");

  a_irq_cause:
    assert property ($rose(irq_flag) |-> (($past(s.st) == ST_XFER) && ($past(s.cnt) == 8'h01))
                     || ($past(s.count) == 8'h00))
    else $error("Interrupt flag set mid-block");

  a_block_swap:
    assert property ((s.st == ST_XFER) && last_word && s.two_block && !s.in_b2 && !sa_write
                     && !cnt_write
                     |=> s.b1_full && s.in_b2 && (s.cnt == s.count) && irq_flag)
    else $error("Block one completion handled wrongly");

  a_block_two:
    assert property ((s.st == ST_XFER) && last_word && s.two_block && s.in_b2
                     |=> !s.b1_full && irq_flag)
    else $error("Block two completion handled wrongly");

  a_cycle_time:
    assert property ($rose(s.st == ST_SYNC) && CPU_ON && MCLK_RUNNING |=> s.we ##1 (s.st == ST_WAIT))
    else $error("Active-mode transfer exceeded three cycles");

  a_zero_count_flag:
    assert property (RESULT_LOAD && (s.count == 8'h00) |=> irq_flag)
    else $error("Result load with zero count left the flag clear");

  a_halt_match:
    assert property (MEM_WE |-> (CPU_HALT == $past(CPU_ON)))
    else $error("CPU halt does not follow the CPU state");

  a_clock_request:
    assert property ((s.st == ST_XFER) && !CPU_ON |-> MCLK_REQ)
    else $error("Master clock not requested during a sleeping transfer");

  a_clock_release:
    assert property ((s.st == ST_IDLE) |-> !MCLK_REQ)
    else $error("Master clock still requested while idle");

  a_wrap_restart:
    assert property ((s.st == ST_XFER) && last_word && s.cont && (!s.two_block || s.in_b2)
                     && !sa_write && !cnt_write
                     |=> (s.ptr == s.start) && (s.cnt == s.count) && !s.in_b2)
    else $error("Continuous pass did not restart at block one");

endmodule // adc_result_transfer_ctrl

`default_nettype wire

// >>> adc_rt_mem_model.sv
// Memory on the far side of the result mover's bus
`timescale 1ns/10ps
`default_nettype none

module adc_rt_mem_model (
  input  wire logic        clk,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic [15:0]      n_writes
);
  logic [15:0] mem [0:32767];
  logic [15:0] n_seen = 16'h0000;

  // One word stored per bus cycle
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[addr[15:1]] <= wdata;
      n_seen <= n_seen + 16'h0001;
    end
  end

  assign n_writes = n_seen;
endmodule // adc_rt_mem_model

`default_nettype wire

// >>> adc_result_transfer_ctrl_test.sv
// Self-checking bench of the result mover
`timescale 1ns/10ps
`default_nettype none

`include "adc_rt_consts.svh"

module adc_result_transfer_ctrl_test;
  logic        clk, rst, stb, we, load, busy, global_irq_enable, serv, cpu_on, mclk_run;
  logic        ack, mem_we, halt, mclk_req, irq, conversion_enable_gate, ref_on;
  logic [7:0]  adr;
  logic [3:0]  sel, chan;
  logic [31:0] dat_w, dat_r, rd, cfg;
  logic [15:0] res, mem_addr, mem_wdata, n_wr, sa;
  integer      n_mismatch, checks, seed, i;

  adc_result_transfer_ctrl i_dut (
    .CLK(clk), .RST(rst), .CYC_I(stb), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .RESULT_LOAD(load), .RESULT_DATA(res),
    .CONVERTER_ACTIVE(busy), .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ_SERVICED(serv), .CPU_ON(cpu_on),
    .MCLK_RUNNING(mclk_run), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we),
    .CPU_HALT(halt), .MCLK_REQ(mclk_req), .IRQ(irq), .CONVERSION_ENABLE_GATE(conversion_enable_gate),
    .INPUT_CHANNEL_SELECT(chan), .REF_ON(ref_on)
  );

  adc_rt_mem_model i_mem (
    .clk(clk), .we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .n_writes(n_wr)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    checks = checks + 1;
    if (seen !== expv) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_r;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
    @(posedge clk);
  endtask

  // Result load; lat 0 means no transfer expected, below 0 any bounded wait
  task automatic ld(input integer lat, input logic [15:0] ea);
    integer k;
    logic [15:0] d;
    d = 16'($random(seed));
    res <= d;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    k = 1;
    while (mem_we !== 1'b1 && k < ((lat == 0) ? 12 : 700)) begin
      @(posedge clk);
      k = k + 1;
    end
    if (lat >= 0) chk(k, (lat == 0) ? 12 : lat);
    else chk(k < 700, 1'b1);
    if (lat != 0) begin
      chk(mem_addr, ea);
      chk(mem_wdata, d);
      chk(halt, cpu_on);
      chk(mclk_req, !cpu_on);
    end
    repeat (2) @(posedge clk);
    if (lat != 0) chk(i_mem.mem[ea[15:1]], {16'h0, d});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hadb7e167;
    n_mismatch = 0;
    checks = 0;
    {rst, busy, global_irq_enable, cpu_on, mclk_run} = 5'h1f;
    {stb, we, load, serv} = 4'h0;
    adr = 8'h00;
    sel = 4'h3;
    dat_w = 32'h0;
    res = 16'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, `OFS_START, 32'h0);
    chk(rd, {16'h0, `START_RESET});
    wb(1'b1, `OFS_CTRL, 32'h20);
    chk(conversion_enable_gate, 1'b1);
    wb(1'b1, `OFS_CTRL, 32'h08);
    busy <= 1'b0;
    wb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    // One block of three words
    sa = 16'($random(seed)) & 16'hfffe;
    wb(1'b1, `OFS_COUNT, 32'h3);
    wb(1'b1, `OFS_START, {16'h0, sa});
    wb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    for (i = 0; i < 4; i++) begin
      ld((i < 3) ? 4 : 0, sa + 16'(2 * i));
      chk(irq, i >= 2);
    end
    chk(n_wr, 16'h3);
    serv <= 1'b1;
    @(posedge clk);
    serv <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wb(1'b1, `OFS_START, {16'h0, sa});
    ld(4, sa);
    // Two blocks of two, continuous, then continuous dropped
    cfg = 32'h0b;
    wb(1'b1, `OFS_CTRL, cfg);
    wb(1'b1, `OFS_COUNT, 32'h2);
    wb(1'b1, `OFS_START, {16'h0, sa});
    for (i = 0; i < 9; i++) begin
      if (i == 5) cfg = 32'h09;
      if (i == 5) wb(1'b1, `OFS_CTRL, cfg);
      ld((i < 8) ? 4 : 0, sa + 16'(2 * (i % 4)));
      wb(1'b0, `OFS_CTRL, 32'h0);
      chk(rd[2], i % 4 == 1 || i % 4 == 2);
      chk(rd[4], i % 2 == 1 && i < 8);
      wb(1'b1, `OFS_CTRL, cfg | 32'h10);
    end
    // CPU asleep, clock running then stopped
    wb(1'b1, `OFS_CTRL, 32'h08);
    wb(1'b1, `OFS_COUNT, 32'h1);
    wb(1'b1, `OFS_START, {16'h0, sa});
    cpu_on <= 1'b0;
    ld(5, sa);
    mclk_run <= 1'b0;
    wb(1'b1, `OFS_START, {16'h0, sa});
    ld(-1, sa);
    {cpu_on, mclk_run} <= 2'b11;
    // No mover: every load flags
    wb(1'b1, `OFS_COUNT, 32'h0);
    wb(1'b1, `OFS_CTRL, 32'h18);
    wb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[1], 1'b0);
    global_irq_enable <= 1'b0;
    ld(0, 16'h0);
    chk(irq, 1'b0);
    wb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd[4], 1'b1);
    wb(1'b0, `OFS_RESULT, 32'h0);
    chk(rd, {16'h0, res});
    global_irq_enable <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(irq, 1'b1);
    // Channel select and reference
    wb(1'b1, `OFS_CTRL, 32'h0a00);
    chk(ref_on, 1'b1);
    chk(chan, 4'ha);
    wb(1'b1, `OFS_CTRL, 32'h0300);
    chk(ref_on, 1'b0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule // adc_result_transfer_ctrl_test

`default_nettype wire
